// [hdl/uartbg_top.sv]
// Full-duplex asynchronous serial channel with its own baud generator,
// a transmit FIFO and a filtered receiver.
// Assumes all inputs synchronous to i_clk and control bits held as levels.
//
// How it works
// - Start, 7/8 data LSB first, parity, stops
// - Even parity generated and checked
// - Odd parity generated and checked
// - Zero parity sends 0, never errors
// - No parity: no bit, no error
// - Line idles high once powered
// - Data write starts framed transmission
// - Complete pulse right after last stop
// - Receive sampled only when powered and enabled
// - Falling edge, count k, low confirms start
// - Stop loads buffer unless overrun
// - Parity error finishes frame, then interrupt
// - Receiver checks exactly one stop bit
// - Parity, framing, overrun flags raise interrupt
// - Reading error status clears all flags
// - Two-sample match filter on receive input
// - Base clock stopped while unpowered
// - Transmit counter cleared while disabled and on write
// - Receive counter cleared when disabled, runs per frame
// - Counters divide base by k; baud base/2k
// - Enable clear resets its own circuit
// - Power off resets status, shift, buffer
`timescale 1ns/100ps

// ----------------------------------------------------------------------
// FIFO in the transmit data path
// ----------------------------------------------------------------------
module uartbg_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_clr,
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } uartbg_fifo_state_t;

    uartbg_fifo_state_t state_reg;
    uartbg_fifo_state_t state_next;
    logic push;
    logic pop;

    // Handshake terms
    assign o_in_ready = (state_reg.cnt != (AW+1)'(DEPTH));
    assign o_out_valid = (state_reg.cnt != '0);
    assign o_out_data = state_reg.mem[state_reg.rp];
    assign push = i_in_valid && o_in_ready;
    assign pop = i_out_ready && o_out_valid;

    // Pointer and occupancy update
    always_comb begin
        state_next = state_reg;
        if (push) begin
            state_next.mem[state_reg.wp] = i_in_data;
            state_next.wp = (state_reg.wp == AW'(DEPTH - 1)) ? '0 : state_reg.wp + 1'b1;
        end
        if (pop) begin
            state_next.rp = (state_reg.rp == AW'(DEPTH - 1)) ? '0 : state_reg.rp + 1'b1;
        end
        state_next.cnt = state_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
        if (i_clr) begin
            state_next.wp = '0;
            state_next.rp = '0;
            state_next.cnt = '0;
        end
    end

    // State register
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end
endmodule

// ----------------------------------------------------------------------
// Channel top
// ----------------------------------------------------------------------
module uartbg_top (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_block_power_enable,
    input wire logic i_transmit_enable,
    input wire logic i_receive_enable,
    input wire logic [1:0] i_parity_mode,
    input wire logic i_char_len_8,
    input wire logic i_two_stop,
    input wire logic [1:0] i_base_clock_select,
    input wire logic i_ext_base_tick,
    input wire logic [4:0] i_divisor,
    input wire logic i_tx_valid,
    input wire logic [7:0] i_tx_data,
    output logic o_tx_ready,
    output logic o_serial_data_out,
    output logic o_tx_complete_irq,
    input wire logic i_serial_data_in,
    output logic [7:0] o_rx_data,
    output logic o_rx_buffer_full,
    input wire logic i_rx_buffer_read,
    output logic o_rx_complete_irq,
    output logic [2:0] o_error_status,
    input wire logic i_error_status_read
);
    typedef struct packed {
        logic [2:0] pre;
        logic base_tick;
        logic rx_a;
        logic rx_b;
        logic rx_filt;
        uartbg_pkg::uartbg_tx_state_t tx_st;
        logic [4:0] tx_cnt;
        logic tx_half;
        logic [3:0] tx_left;
        logic [11:0] tx_sh;
        logic tx_irq;
        uartbg_pkg::uartbg_rx_state_t rx_st;
        logic [4:0] rx_cnt;
        logic rx_half;
        logic [3:0] rx_pos;
        logic [7:0] rx_sh;
        logic rx_par;
        logic rx_irq;
        logic [7:0] rx_buf;
        logic rx_full;
        logic [2:0] err;
    } uartbg_state_t;

    uartbg_state_t state_reg;
    uartbg_state_t state_next;
    logic tx_on;
    logic rx_on;
    logic tx_pop;
    logic fifo_valid;
    logic [7:0] fifo_data;
    logic rx_in;
    logic rx_done;

    // Parity bit for a character under the selected mode
    function automatic logic par_bit(input logic [7:0] d, input logic len8, input logic [1:0] mode);
        logic ones;
        ones = len8 ? ^d : ^d[6:0];
        case (mode)
            uartbg_pkg::PAR_ODD: par_bit = ~ones;
            uartbg_pkg::PAR_EVEN: par_bit = ones;
            default: par_bit = 1'b0;
        endcase
    endfunction

    // True on the base tick that ends one half bit (k base ticks)
    function automatic logic cnt_wrap(input logic [4:0] cnt, input logic [4:0] k);
        cnt_wrap = (cnt == k - 5'h01);
    endfunction

    assign tx_on = i_block_power_enable && i_transmit_enable;
    assign rx_on = i_block_power_enable && i_receive_enable;
    assign tx_pop = tx_on && (state_reg.tx_st == uartbg_pkg::TX_IDLE);
    assign rx_in = i_block_power_enable ? i_serial_data_in : 1'b1;

    // Outputs
    assign o_serial_data_out = (state_reg.tx_st == uartbg_pkg::TX_SEND) ? state_reg.tx_sh[0] : 1'b1;
    assign o_tx_complete_irq = state_reg.tx_irq;
    assign o_rx_complete_irq = state_reg.rx_irq;
    assign o_rx_data = state_reg.rx_buf;
    assign o_rx_buffer_full = state_reg.rx_full;
    assign o_error_status = state_reg.err;

    uartbg_fifo #(
        .WIDTH(uartbg_pkg::DATA_W),
        .DEPTH(uartbg_pkg::FIFO_DEPTH)
    ) u_tx_fifo (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_clr(!tx_on),
        .i_in_valid(i_tx_valid),
        .i_in_data(i_tx_data),
        .o_in_ready(o_tx_ready),
        .o_out_valid(fifo_valid),
        .o_out_data(fifo_data),
        .i_out_ready(tx_pop)
    );

    // Next-state logic for prescaler, filter, transmitter and receiver
    always_comb begin
        logic tick_raw;
        logic [11:0] f;
        logic [3:0] idx;
        logic [3:0] stop_pos;
        logic [2:0] new_err;
        logic bit_v;
        tick_raw = 1'b0;
        f = '1;
        idx = '0;
        stop_pos = '0;
        new_err = '0;
        bit_v = 1'b0;
        rx_done = 1'b0;
        state_next = state_reg;
        state_next.tx_irq = 1'b0;
        state_next.rx_irq = 1'b0;

        // Base clock prescaler, stopped while unpowered
        state_next.pre = state_reg.pre + 3'h1;
        case (i_base_clock_select)
            uartbg_pkg::BASE_DIV2: tick_raw = state_reg.pre[0];
            uartbg_pkg::BASE_DIV4: tick_raw = (state_reg.pre[1:0] == 2'h3);
            uartbg_pkg::BASE_DIV8: tick_raw = (state_reg.pre == 3'h7);
            default: tick_raw = i_ext_base_tick;
        endcase
        state_next.base_tick = tick_raw && i_block_power_enable;

        // Two samples must agree before the internal level moves
        if (state_reg.base_tick) begin
            state_next.rx_a = rx_in;
            state_next.rx_b = state_reg.rx_a;
            if (state_reg.rx_a == state_reg.rx_b) begin
                state_next.rx_filt = state_reg.rx_b;
            end
        end

        // Transmitter
        case (state_reg.tx_st)
            uartbg_pkg::TX_IDLE: begin
                if (tx_on && fifo_valid) begin
                    f[0] = 1'b0;
                    f[7:1] = fifo_data[6:0];
                    if (i_char_len_8) begin
                        f[8] = fifo_data[7];
                    end
                    idx = i_char_len_8 ? 4'h9 : 4'h8;
                    if (i_parity_mode != uartbg_pkg::PAR_NONE) begin
                        f[idx] = par_bit(fifo_data, i_char_len_8, i_parity_mode);
                        idx = idx + 4'h1;
                    end
                    state_next.tx_sh = f;
                    state_next.tx_left = idx + (i_two_stop ? 4'h2 : 4'h1);
                    state_next.tx_cnt = '0;
                    state_next.tx_half = 1'b0;
                    state_next.tx_st = uartbg_pkg::TX_SEND;
                end
            end
            uartbg_pkg::TX_SEND: begin
                if (state_reg.base_tick) begin
                    state_next.tx_cnt = state_reg.tx_cnt + 5'h1;
                    if (cnt_wrap(state_reg.tx_cnt, i_divisor)) begin
                        state_next.tx_cnt = '0;
                        state_next.tx_half = ~state_reg.tx_half;
                        if (state_reg.tx_half) begin
                            state_next.tx_sh = {1'b1, state_reg.tx_sh[11:1]};
                            state_next.tx_left = state_reg.tx_left - 4'h1;
                            if (state_reg.tx_left == 4'h1) begin
                                state_next.tx_irq = 1'b1;
                                state_next.tx_st = uartbg_pkg::TX_IDLE;
                            end
                        end
                    end
                end
            end
            default: state_next.tx_st = uartbg_pkg::TX_IDLE;
        endcase
        if (!tx_on) begin
            state_next.tx_st = uartbg_pkg::TX_IDLE;
            state_next.tx_cnt = '0;
            state_next.tx_half = 1'b0;
            state_next.tx_left = '0;
            state_next.tx_irq = 1'b0;
        end

        // Receiver
        stop_pos = (i_char_len_8 ? 4'h8 : 4'h7) + ((i_parity_mode != uartbg_pkg::PAR_NONE) ? 4'h1 : 4'h0);
        case (state_reg.rx_st)
            uartbg_pkg::RX_IDLE: begin
                if (state_reg.rx_filt && !state_next.rx_filt) begin
                    state_next.rx_st = uartbg_pkg::RX_START;
                    state_next.rx_cnt = '0;
                end
            end
            uartbg_pkg::RX_START: begin
                if (state_reg.base_tick) begin
                    state_next.rx_cnt = state_reg.rx_cnt + 5'h1;
                    if (cnt_wrap(state_reg.rx_cnt, i_divisor)) begin
                        state_next.rx_cnt = '0;
                        state_next.rx_half = 1'b0;
                        state_next.rx_pos = '0;
                        state_next.rx_sh = '0;
                        state_next.rx_st = state_reg.rx_filt ? uartbg_pkg::RX_IDLE : uartbg_pkg::RX_DATA;
                    end
                end
            end
            uartbg_pkg::RX_DATA: begin
                if (state_reg.base_tick) begin
                    state_next.rx_cnt = state_reg.rx_cnt + 5'h1;
                    if (cnt_wrap(state_reg.rx_cnt, i_divisor)) begin
                        state_next.rx_cnt = '0;
                        state_next.rx_half = ~state_reg.rx_half;
                        if (state_reg.rx_half) begin
                            bit_v = state_reg.rx_filt;
                            state_next.rx_pos = state_reg.rx_pos + 4'h1;
                            if (state_reg.rx_pos == stop_pos) begin
                                rx_done = 1'b1;
                            end else if (state_reg.rx_pos < (i_char_len_8 ? 4'h8 : 4'h7)) begin
                                state_next.rx_sh[state_reg.rx_pos[2:0]] = bit_v;
                            end else begin
                                state_next.rx_par = bit_v;
                            end
                        end
                    end
                end
            end
            default: state_next.rx_st = uartbg_pkg::RX_IDLE;
        endcase

        // Frame end: flags, buffer load and interrupt
        if (rx_done) begin
            if ((i_parity_mode == uartbg_pkg::PAR_ODD) || (i_parity_mode == uartbg_pkg::PAR_EVEN)) begin
                new_err[uartbg_pkg::ERR_PARITY] = (state_reg.rx_par !=
                    par_bit(state_reg.rx_sh, i_char_len_8, i_parity_mode));
            end
            new_err[uartbg_pkg::ERR_FRAMING] = ~bit_v;
            new_err[uartbg_pkg::ERR_OVERRUN] = state_reg.rx_full && !i_rx_buffer_read;
            if (!new_err[uartbg_pkg::ERR_OVERRUN]) begin
                state_next.rx_buf = state_reg.rx_sh;
            end
            state_next.rx_irq = 1'b1;
            state_next.rx_st = uartbg_pkg::RX_IDLE;
        end

        // Buffer full flag: a load in the read cycle wins
        if (i_rx_buffer_read) begin
            state_next.rx_full = 1'b0;
        end
        if (rx_done && !new_err[uartbg_pkg::ERR_OVERRUN]) begin
            state_next.rx_full = 1'b1;
        end

        // Error flags: cleared by a status read, new errors win
        state_next.err = (i_error_status_read ? 3'h0 : state_reg.err) | new_err;

        if (!rx_on) begin
            state_next.rx_st = uartbg_pkg::RX_IDLE;
            state_next.rx_cnt = '0;
            state_next.rx_half = 1'b0;
            state_next.rx_pos = '0;
            state_next.rx_irq = 1'b0;
            state_next.err = state_reg.err & ~{3{i_error_status_read}};
            state_next.rx_full = state_reg.rx_full && !i_rx_buffer_read;
            state_next.rx_buf = state_reg.rx_buf;
        end

        // Power off clears the whole channel
        if (!i_block_power_enable) begin
            state_next = '0;
            state_next.rx_a = 1'b1;
            state_next.rx_b = 1'b1;
            state_next.rx_filt = 1'b1;
            state_next.tx_sh = '1;
        end
    end

    // State register
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_reg <= '0;
            state_reg.rx_a <= 1'b1;
            state_reg.rx_b <= 1'b1;
            state_reg.rx_filt <= 1'b1;
            state_reg.tx_sh <= '1;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_tx_idle_high: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_reg.tx_st == uartbg_pkg::TX_IDLE) |-> o_serial_data_out)
        else $error("line not idle high");
    a_tx_start_bit: assert property (@(posedge i_clk) disable iff (i_rst)
        (tx_pop && fifo_valid) |=> (!o_serial_data_out && state_reg.tx_st == uartbg_pkg::TX_SEND))
        else $error("write did not start a frame");
    a_tx_done_idle: assert property (@(posedge i_clk) disable iff (i_rst)
        o_tx_complete_irq |-> (state_reg.tx_st == uartbg_pkg::TX_IDLE && $past(o_serial_data_out)))
        else $error("complete pulse not after stop bit");
    a_tx_cnt_held: assert property (@(posedge i_clk) disable iff (i_rst)
        !tx_on |=> (state_reg.tx_cnt == 5'h0 && !o_tx_complete_irq))
        else $error("transmit counter runs while disabled");
    a_rx_cnt_held: assert property (@(posedge i_clk) disable iff (i_rst)
        !rx_on |=> (state_reg.rx_cnt == 5'h0 && state_reg.rx_st == uartbg_pkg::RX_IDLE))
        else $error("receive counter runs while disabled");
    a_err_read_clear: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_error_status_read && !rx_done) |=> (o_error_status == 3'h0))
        else $error("status read did not clear flags");
    a_no_parity_err: assert property (@(posedge i_clk) disable iff (i_rst)
        (rx_done && i_parity_mode < uartbg_pkg::PAR_ODD && !o_error_status[uartbg_pkg::ERR_PARITY])
        |=> !o_error_status[uartbg_pkg::ERR_PARITY])
        else $error("parity error without checked parity");
    a_overrun_keep: assert property (@(posedge i_clk) disable iff (i_rst)
        (rx_done && o_rx_buffer_full && !i_rx_buffer_read && rx_on)
        |=> ($stable(o_rx_data) && o_error_status[uartbg_pkg::ERR_OVERRUN] && o_rx_complete_irq))
        else $error("overrun changed buffer or lost flag");
    a_power_off_clr: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_block_power_enable |=> (o_error_status == 3'h0 && o_rx_data == 8'h00 && !state_reg.base_tick))
        else $error("power off did not clear channel");
endmodule

// [hdl/uartbg_pkg.sv]
// Constants and types shared by the serial channel with its baud generator.
// Assumes a single 125 MHz system clock and a synchronous active-high reset.
package uartbg_pkg;

    // ------------------------------------------------------------------
    // Timing and sizes
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int DIV_MIN = 8;
    localparam int DIV_MAX = 31;
    localparam int FIFO_DEPTH = 8;
    localparam int DATA_W = 8;

    // ------------------------------------------------------------------
    // Parity mode encoding
    // ------------------------------------------------------------------
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_ZERO = 2'h1;
    localparam logic [1:0] PAR_ODD = 2'h2;
    localparam logic [1:0] PAR_EVEN = 2'h3;

    // ------------------------------------------------------------------
    // Base clock selection and error status fields
    // ------------------------------------------------------------------
    localparam logic [1:0] BASE_EXT = 2'h0;
    localparam logic [1:0] BASE_DIV2 = 2'h1;
    localparam logic [1:0] BASE_DIV4 = 2'h2;
    localparam logic [1:0] BASE_DIV8 = 2'h3;
    localparam int ERR_OVERRUN = 0;
    localparam int ERR_FRAMING = 1;
    localparam int ERR_PARITY = 2;

    // ------------------------------------------------------------------
    // State encodings
    // ------------------------------------------------------------------
    typedef enum logic [0:0] {TX_IDLE = 1'b0, TX_SEND = 1'b1} uartbg_tx_state_t;
    typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10} uartbg_rx_state_t;

endpackage

// [tb/uartbg_remote.sv]
// Remote serial device on the line side: sends frames in, captures frames out.
// Assumes the bench clock and a bit time of bit_cyc clock cycles, set between frames.
`timescale 1ns/100ps
module uartbg_remote #(
    parameter int BIT_CYC = 32
) (
    input wire logic i_clk,
    input wire logic i_line,
    output logic o_line
);
    // Line idles high between frames
    initial o_line = 1'b1;

    // Bit time in clock cycles, changed by the bench for other baud rates
    int bit_cyc = BIT_CYC;

    // Start bit, then nb bits of f in order, then idle high
    task automatic send(input logic [11:0] f, input int nb);
        @(posedge i_clk);
        #1 o_line = 1'b0;
        repeat (bit_cyc) @(posedge i_clk);
        for (int i = 0; i < nb; i++) begin
            #1 o_line = f[i];
            repeat (bit_cyc) @(posedge i_clk);
        end
        #1 o_line = 1'b1;
    endtask

    // Short low pulse on an idle line
    task automatic pulse_low(input int c);
        @(posedge i_clk);
        #1 o_line = 1'b0;
        repeat (c) @(posedge i_clk);
        #1 o_line = 1'b1;
    endtask

    // Waits for a start bit, then samples nb bits at their centres
    task automatic recv(input int nb, output logic [11:0] f, output logic ok);
        int t;
        f = '0;
        t = 0;
        while (i_line !== 1'b0 && t < 4000) begin
            @(posedge i_clk);
            t++;
        end
        repeat (bit_cyc / 2) @(posedge i_clk);
        ok = (t < 4000) && (i_line === 1'b0);
        for (int i = 0; i < nb; i++) begin
            repeat (bit_cyc) @(posedge i_clk);
            f[i] = i_line;
        end
    endtask
endmodule

// [tb/async_serial_uart_with_baud_gen_tb.sv]
// Self-checking bench for the serial channel with its baud generator.
// Assumes base clock = clk/2 and k = 8, so one bit lasts 32 clock cycles.
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module async_serial_uart_with_baud_gen_tb;
    localparam int BIT = 32;
    logic clk, rst, pwr, txe, rxe, l8, s2, txv, rbr, esr, rxl;
    logic txr, txl, txi, full, rxi, ok;
    logic [1:0] pm;
    logic [7:0] txd, rxd;
    logic [2:0] est;
    logic [11:0] f, e;
    logic [1:0] sel = 2'h1;
    logic [4:0] div = 5'h08;
    logic xt = 1'b0;
    int miscompares = 0, n_tests = 0, n_rxi = 0, n_txi = 0, k, n;

    uartbg_top dut (.i_clk(clk), .i_rst(rst), .i_block_power_enable(pwr), .i_transmit_enable(txe),
        .i_receive_enable(rxe), .i_parity_mode(pm), .i_char_len_8(l8), .i_two_stop(s2),
        .i_base_clock_select(sel), .i_ext_base_tick(xt), .i_divisor(div), .i_tx_valid(txv),
        .i_tx_data(txd), .o_tx_ready(txr), .o_serial_data_out(txl), .o_tx_complete_irq(txi),
        .i_serial_data_in(rxl), .o_rx_data(rxd), .o_rx_buffer_full(full), .i_rx_buffer_read(rbr),
        .o_rx_complete_irq(rxi), .o_error_status(est), .i_error_status_read(esr));
    uartbg_remote #(.BIT_CYC(BIT)) rem (.i_clk(clk), .i_line(txl), .o_line(rxl));

    // Clock and interrupt pulse counters
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // External base tick, high every other cycle
    always @(posedge clk) #1 xt = ~xt;
    always @(posedge clk) begin
        if (rxi === 1'b1) n_rxi++;
        if (txi === 1'b1) n_txi++;
    end

    // Verdict and end of run
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Frame bits after the start bit: data, parity, stop(s)
    function automatic void frame(input logic [7:0] d, input logic [1:0] p, input logic bp, input logic bs);
        n = l8 ? 8 : 7;
        e = '0;
        for (int i = 0; i < n; i++) e[i] = d[i];
        if (p != uartbg_pkg::PAR_NONE) begin
            e[n] = bp ^ ((p == uartbg_pkg::PAR_EVEN) ? ^e[7:0] : (p == uartbg_pkg::PAR_ODD) ? ~^e[7:0] : 1'b0);
            n++;
        end
        e[n] = ~bs;
        n = n + 1 + int'(s2);
        e[n-1] = e[n-1] | s2;
    endfunction

    task automatic cfg(input logic [1:0] p, input logic a, input logic b);
        @(posedge clk);
        #1 pm = p;
        l8 = a;
        s2 = b;
    endtask

    // Holds valid until ready is seen at an edge; lowers it unless more follow
    task automatic write(input logic [7:0] d, input logic more);
        int t;
        t = 0;
        txv = 1'b1;
        txd = d;
        while (txr !== 1'b1 && t < 9000) begin
            @(posedge clk);
            #1 t++;
        end
        @(posedge clk);
        #1 txv = more;
        if (t >= 9000) begin
            miscompares++;
            final_report();
        end
    endtask

    // One-cycle read pulse: status when st, buffer otherwise
    task automatic rd(input logic st);
        @(posedge clk);
        #1 esr = st;
        rbr = ~st;
        @(posedge clk);
        #1 esr = 1'b0;
        rbr = 1'b0;
    endtask

    task automatic get();
        rem.recv(n, f, ok);
        `CHK(ok, 1'b1)
        if (ok !== 1'b1) final_report();
    endtask

    // Every parity mode once on transmit, between them both lengths and both stop counts
    task automatic t_tx();
        for (int m = 0; m < 4; m++) begin
            cfg(m[1:0], m[0], m[1]);
            frame(8'hb6 ^ m[7:0], m[1:0], 1'b0, 1'b0);
            k = n_txi;
            write(8'hb6 ^ m[7:0], 1'b0);
            get();
            `CHK(f, e)
            repeat (BIT) @(posedge clk);
            `CHK(n_txi, k + 1)
            `CHK(txl, 1'b1)
        end
    endtask

    // Transmit disable in mid-frame returns the line to idle, no completion
    task automatic t_txoff();
        k = n_txi;
        write(8'h00, 1'b0);
        repeat (BIT * 2) @(posedge clk);
        #1 txe = 1'b0;
        repeat (3) @(posedge clk);
        `CHK(txl, 1'b1)
        repeat (BIT * 12) @(posedge clk);
        `CHK(n_txi, k)
        #1 txe = 1'b1;
    endtask

    // Nine writes back to back fill the queue, frames leave in order
    task automatic t_fifo();
        cfg(2'h3, 1'b1, 1'b0);
        k = n_txi;
        for (int i = 0; i < 9; i++) write(8'h1d * i[7:0], i < 8);
        `CHK(txr, 1'b0)
        for (int i = 0; i < 9; i++) begin
            frame(8'h1d * i[7:0], 2'h3, 1'b0, 1'b0);
            get();
            `CHK(f, e)
        end
        repeat (BIT) @(posedge clk);
        `CHK(n_txi, k + 9)
    endtask

    // Receive in all modes, parity flipped in the upper half
    task automatic t_rx();
        for (int m = 0; m < 8; m++) begin
            cfg(m[1:0], m[0], m[1]);
            frame(8'h5a ^ m[7:0], m[1:0], m[2], 1'b0);
            k = n_rxi;
            rem.send(e, n);
            repeat (4) @(posedge clk);
            `CHK(rxd, (8'h5a ^ m[7:0]) & (m[0] ? 8'hff : 8'h7f))
            `CHK(est, {m[2] & m[1], 2'h0})
            `CHK(n_rxi, k + 1)
            `CHK(full, 1'b1)
            rd(1'b1);
            `CHK(est, 3'h0)
            rd(1'b0);
            `CHK(full, 1'b0)
        end
    endtask

    // Every base clock source with divisor 9, one frame each way; then back to clk/2 and 8
    task automatic t_baud();
        for (int s = 0; s < 5; s++) begin
            @(posedge clk);
            #1 {txe, rxe} = 2'h0;
            sel = (s < 4) ? s[1:0] : 2'h1;
            div = (s < 4) ? 5'h09 : 5'h08;
            rem.bit_cyc = (s == 4) ? BIT : 18 << ((s == 0) ? 1 : s);
            cfg(2'h2, 1'b1, 1'b1);
            {txe, rxe} = 2'h3;
            if (s < 4) begin
                frame(8'h9c, 2'h2, 1'b0, 1'b0);
                write(8'h9c, 1'b0);
                get();
                `CHK(f, e)
                k = n_rxi;
                rem.send(e, n);
                repeat (4) @(posedge clk);
                `CHK(rxd, 8'h9c)
                `CHK(n_rxi, k + 1)
                `CHK(est, 3'h0)
                rd(1'b1);
                rd(1'b0);
            end
        end
    endtask

    // Framing, overrun, noise and power off
    task automatic t_err();
        cfg(2'h0, 1'b1, 1'b0);
        frame(8'hc3, 2'h0, 1'b0, 1'b1);
        rem.send(e, n);
        repeat (4) @(posedge clk);
        `CHK(est, 3'h2)
        rd(1'b1);
        rd(1'b0);
        k = n_rxi;
        frame(8'h11, 2'h0, 1'b0, 1'b0);
        rem.send(e, n);
        frame(8'h22, 2'h0, 1'b0, 1'b0);
        rem.send(e, n);
        repeat (4) @(posedge clk);
        `CHK(est, 3'h1)
        `CHK(rxd, 8'h11)
        `CHK(n_rxi, k + 2)
        rem.pulse_low(1);
        repeat (BIT) @(posedge clk);
        rem.pulse_low(8);
        repeat (BIT * 3) @(posedge clk);
        `CHK(n_rxi, k + 2)
        #1 pwr = 1'b0;
        repeat (3) @(posedge clk);
        `CHK(est, 3'h0)
        `CHK(full, 1'b0)
        `CHK(rxd, 8'h00)
        `CHK(txl, 1'b1)
        rem.send(e, n);
        repeat (4) @(posedge clk);
        `CHK(n_rxi, k + 2)
    endtask

    // Reset, power up, enable, scenarios
    initial begin
        {rst, pwr, txe, rxe, txv, rbr, esr, s2} = 8'hff;
        {pwr, txe, rxe, txv, rbr, esr, s2} = 7'h00;
        pm = 2'h0;
        l8 = 1'b1;
        txd = 8'h00;
        repeat (20) @(posedge clk);
        #1 rst = 1'b0;
        pwr = 1'b1;
        repeat (2) @(posedge clk);
        `CHK(txl, 1'b1)
        #1 txe = 1'b1;
        rxe = 1'b1;
        t_tx();
        t_txoff();
        t_fifo();
        t_rx();
        t_baud();
        t_err();
        final_report();
    end
endmodule
